/* File: srvrb_regbank.sv */
// Chosen here: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module srvrb_regbank #(
  // identification words, values arbitrary
  parameter logic [31:0] IDENT_TYPE    = 32'h5352_5642,
  parameter logic [31:0] IDENT_VERSION = 32'h0001_0000,
  parameter logic [31:0] IDENT_DATE    = 32'h0000_0001
) (
  // clock and reset
  input  wire logic                       ref_clk,
  input  wire logic                       reset_n,
  // avalon-mm slave, byte address
  input  wire logic [8:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic      [31:0]                avs_readdata,
  output logic                            avs_waitrequest,
  // raw converter words (two 16-bit samples each)
  input  wire logic [31:0]                conv_raw_0,
  input  wire logic [31:0]                conv_raw_1,
  input  wire logic [31:0]                conv_raw_2,
  input  wire logic [31:0]                conv_raw_3,
  // measured phase currents
  input  wire logic [15:0]                meas_cur_ux,
  input  wire logic [15:0]                meas_cur_wy,
  // angle sensor values
  input  wire logic [15:0]                ang_ux,
  input  wire logic [15:0]                ang_v,
  input  wire logic [15:0]                ang_wy,
  input  wire logic [15:0]                ang_n,
  // configuration to the datapath
  output logic      [31:0]                modulator_config_pair,
  output logic      [31:0]                modulator_clock_a,
  output logic      [31:0]                modulator_clock_b,
  output logic      [31:0]                decimation_ratio_pair,
  output logic      [31:0]                current_ch1_gain_offset,
  output logic      [31:0]                current_ch0_gain_offset,
  output logic      [31:0]                current_channel_routing,
  output logic      [31:0]                external_current_values,
  output logic      [31:0]                analog_input_stage_setup,
  output logic      [31:0]                angle_sensor_ch0_gain_offset,
  output logic      [31:0]                angle_sensor_ch1_gain_offset,
  output logic      [31:0]                angle_sensor_ch2_gain_offset,
  output logic      [31:0]                angle_sensor_routing,
  output logic      [31:0]                gate_output_polarity,
  output logic      [31:0]                pwm_period_count,
  output logic      [31:0]                dead_time_high_low,
  output logic      [31:0]                chopper_mode_setup,
  // derived phase currents
  output logic      [15:0]                phase_cur_ux,
  output logic      [15:0]                phase_cur_wy,
  output logic      [15:0]                phase_cur_v
);
  import srvrb_pkg::*;

  // ------------------------------------------------------------
  // bus handshake
  // ------------------------------------------------------------
  srvrb_bus_t          state_r;
  srvrb_bus_t          state_nxt;
  logic                req;
  logic                take;
  logic [IDX_W-1:0]    idx;
  logic [DATA_W-1:0]   rdata_nxt;
  logic [DATA_W-1:0]   rdata_r;

  assign req  = avs_read | avs_write;
  // word index from the byte address: one word per register
  assign idx  = avs_address[8:2];
  // the request is taken on the second cycle it is held
  assign take = req && (state_r == BUS_ANSWER);
  assign avs_waitrequest = req && (state_r != BUS_ANSWER);

  always_comb begin
    case (state_r)
      BUS_IDLE:   state_nxt = req ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: state_nxt = BUS_IDLE;
      default:    state_nxt = BUS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) state_r <= BUS_IDLE;
    else state_r <= state_nxt;
  end

  // ------------------------------------------------------------
  // stacked registers
  // ------------------------------------------------------------
  logic [DATA_W-1:0]   ident_sel;
  logic [DATA_W-1:0]   ident_data;
  logic [DATA_W-1:0]   conv_sel;
  logic [DATA_W-1:0]   conv_data;
  logic                ident_we;
  logic                conv_we;
  logic [DATA_W-1:0]   ident_wdata;
  logic [DATA_W-1:0]   conv_wdata;

  assign ident_we = take && avs_write && (idx == A_IDENT_SEL);
  assign conv_we  = take && avs_write && (idx == A_CONV_SEL);
  assign ident_wdata = be_merge(ident_sel, avs_writedata,
                                avs_byteenable);
  assign conv_wdata  = be_merge(conv_sel, avs_writedata,
                                avs_byteenable);

  srvrb_stack_sel #(
    .SUBS      (IDENT_SUBS)
  ) u_ident (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .sel_we    (ident_we),
    .sel_wdata (ident_wdata),
    .sub_data  ({IDENT_DATE, IDENT_VERSION, IDENT_TYPE}),
    .sel_r     (ident_sel),
    .data_out  (ident_data)
  );

  srvrb_stack_sel #(
    .SUBS      (CONV_SUBS)
  ) u_conv (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .sel_we    (conv_we),
    .sel_wdata (conv_wdata),
    .sub_data  ({conv_raw_3, conv_raw_2, conv_raw_1, conv_raw_0}),
    .sel_r     (conv_sel),
    .data_out  (conv_data)
  );

  // ------------------------------------------------------------
  // configuration storage
  // ------------------------------------------------------------
  logic [DATA_W-1:0]   cfg_r [0:CFG_SLOTS-1];
  logic [4:0]          slot;

  assign slot = idx[4:0];

  // words are stored exactly as delivered, per byte lane
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CFG_SLOTS; i++) cfg_r[i] <= CFG_RESET;
    end else if (take && avs_write && is_rw(idx)) begin
      cfg_r[slot] <= be_merge(cfg_r[slot], avs_writedata,
                              avs_byteenable);
    end
  end

  assign modulator_config_pair        = cfg_r[A_MOD_CFG[4:0]];
  assign modulator_clock_a            = cfg_r[A_MOD_CLK_A[4:0]];
  assign modulator_clock_b            = cfg_r[A_MOD_CLK_B[4:0]];
  assign decimation_ratio_pair        = cfg_r[A_DECIM[4:0]];
  assign current_ch1_gain_offset      = cfg_r[A_CUR1_GO[4:0]];
  assign current_ch0_gain_offset      = cfg_r[A_CUR0_GO[4:0]];
  assign current_channel_routing      = cfg_r[A_CUR_ROUTE[4:0]];
  assign external_current_values      = cfg_r[A_CUR_EXT[4:0]];
  assign analog_input_stage_setup     = cfg_r[A_AIN_SETUP[4:0]];
  assign angle_sensor_ch0_gain_offset = cfg_r[A_ANG0_GO[4:0]];
  assign angle_sensor_ch1_gain_offset = cfg_r[A_ANG1_GO[4:0]];
  assign angle_sensor_ch2_gain_offset = cfg_r[A_ANG2_GO[4:0]];
  assign angle_sensor_routing         = cfg_r[A_ANG_ROUTE[4:0]];
  assign gate_output_polarity         = cfg_r[A_GATE_POL[4:0]];
  assign pwm_period_count             = cfg_r[A_PWM_PER[4:0]];
  assign dead_time_high_low           = cfg_r[A_DEAD_TIME[4:0]];
  assign chopper_mode_setup           = cfg_r[A_CHOP_MODE[4:0]];

  // ------------------------------------------------------------
  // phase currents
  // ------------------------------------------------------------
  logic [HALF_W-1:0]   src_ux;
  logic [HALF_W-1:0]   src_wy;
  logic                use_ext;

  // routing bit picks the externally written pair as source
  assign use_ext = current_channel_routing[ROUTE_EXT_BIT];
  assign src_ux = use_ext ? external_current_values[HALF_W-1:0]
                          : meas_cur_ux;
  assign src_wy = use_ext ? external_current_values[DATA_W-1:HALF_W]
                          : meas_cur_wy;

  srvrb_phase_calc u_phase (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .cur_ux    (src_ux),
    .cur_wy    (src_wy),
    .ph_ux_r   (phase_cur_ux),
    .ph_wy_r   (phase_cur_wy),
    .ph_v_r    (phase_cur_v)
  );

  // ------------------------------------------------------------
  // angle values
  // ------------------------------------------------------------
  logic [ANGLE_W-1:0]  ang_ux_r;
  logic [ANGLE_W-1:0]  ang_v_r;
  logic [ANGLE_W-1:0]  ang_wy_r;
  logic [ANGLE_W-1:0]  ang_n_r;

  // one period is the full 16-bit range, wrapping naturally
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ang_ux_r <= '0;
      ang_v_r  <= '0;
      ang_wy_r <= '0;
      ang_n_r  <= '0;
    end else begin
      ang_ux_r <= ANGLE_W'(ang_ux);
      ang_v_r  <= ANGLE_W'(ang_v);
      ang_wy_r <= ANGLE_W'(ang_wy);
      ang_n_r  <= ANGLE_W'(ang_n);
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // whole packed word is returned; host unpacks fields
  always_comb begin
    case (idx)
      A_IDENT_READ: rdata_nxt = ident_data;
      A_IDENT_SEL:  rdata_nxt = ident_sel;
      A_CONV_READ:  rdata_nxt = conv_data;
      A_CONV_SEL:   rdata_nxt = conv_sel;
      A_PH_WY_UX:   rdata_nxt = {phase_cur_wy, phase_cur_ux};
      A_PH_V:       rdata_nxt = {16'h0000, phase_cur_v};
      A_ANG_WY_UX:  rdata_nxt = {ang_wy_r, ang_ux_r};
      A_ANG_VN:     rdata_nxt = {ang_n_r, ang_v_r};
      default: begin
        if (is_rw(idx)) rdata_nxt = cfg_r[slot];
        else rdata_nxt = '0;
      end
    endcase
  end

  // captured on the first cycle, stands at the answer edge
  always_ff @(posedge ref_clk) begin
    if (!reset_n) rdata_r <= '0;
    else if (avs_read && (state_r == BUS_IDLE)) rdata_r <= rdata_nxt;
  end

  assign avs_readdata = rdata_r;

endmodule
`default_nettype wire

/* File: srvrb_pkg.sv */
// Notes on behaviour
// - decode 128 addresses, 32-bit words
// - words hold 32, 2x16 or mixed fields
// - two stacked data registers follow their selects
// - write select, then read data register
// - identity readout 0x00 RO, select 0x01 RW
// - converter readout 0x02 RO, select 0x03 RW
// - angles span 65536 counts, 16-bit wrap
// - third phase current derived from two measured or two written
package srvrb_pkg;

  localparam int REG_COUNT = 128;
  localparam int IDX_W     = 7;
  localparam int DATA_W    = 32;
  localparam int HALF_W    = 16;
  localparam int ANGLE_PERIOD = 65536;
  localparam int ANGLE_W   = $clog2(ANGLE_PERIOD);
  localparam int IDENT_SUBS = 3;
  localparam int CONV_SUBS  = 4;

  localparam logic [IDX_W-1:0] A_IDENT_READ = 7'h00;
  localparam logic [IDX_W-1:0] A_IDENT_SEL  = 7'h01;
  localparam logic [IDX_W-1:0] A_CONV_READ  = 7'h02;
  localparam logic [IDX_W-1:0] A_CONV_SEL   = 7'h03;
  localparam logic [IDX_W-1:0] A_MOD_CFG    = 7'h04;
  localparam logic [IDX_W-1:0] A_MOD_CLK_A  = 7'h05;
  localparam logic [IDX_W-1:0] A_MOD_CLK_B  = 7'h06;
  localparam logic [IDX_W-1:0] A_DECIM      = 7'h07;
  localparam logic [IDX_W-1:0] A_CUR1_GO    = 7'h08;
  localparam logic [IDX_W-1:0] A_CUR0_GO    = 7'h09;
  localparam logic [IDX_W-1:0] A_CUR_ROUTE  = 7'h0A;
  localparam logic [IDX_W-1:0] A_CUR_EXT    = 7'h0B;
  localparam logic [IDX_W-1:0] A_AIN_SETUP  = 7'h0C;
  localparam logic [IDX_W-1:0] A_ANG0_GO    = 7'h0D;
  localparam logic [IDX_W-1:0] A_ANG1_GO    = 7'h0E;
  localparam logic [IDX_W-1:0] A_ANG2_GO    = 7'h0F;
  localparam logic [IDX_W-1:0] A_ANG_ROUTE  = 7'h11;
  localparam logic [IDX_W-1:0] A_PH_WY_UX   = 7'h12;
  localparam logic [IDX_W-1:0] A_PH_V       = 7'h13;
  localparam logic [IDX_W-1:0] A_ANG_WY_UX  = 7'h15;
  localparam logic [IDX_W-1:0] A_ANG_VN     = 7'h16;
  localparam logic [IDX_W-1:0] A_GATE_POL   = 7'h17;
  localparam logic [IDX_W-1:0] A_PWM_PER    = 7'h18;
  localparam logic [IDX_W-1:0] A_DEAD_TIME  = 7'h19;
  localparam logic [IDX_W-1:0] A_CHOP_MODE  = 7'h1A;

  localparam logic [DATA_W-1:0] SEL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
  localparam int ROUTE_EXT_BIT = 0;
  localparam int CFG_SLOTS = 32;

  typedef enum logic [0:0] {
    BUS_IDLE   = 1'b0,
    BUS_ANSWER = 1'b1
  } srvrb_bus_t;

  function automatic logic [DATA_W-1:0] be_merge(
    input logic [DATA_W-1:0] old_w,
    input logic [DATA_W-1:0] new_w,
    input logic [3:0]        be);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) res[b*8 +: 8] = new_w[b*8 +: 8];
    end
    return res;
  endfunction

  function automatic logic is_rw(input logic [IDX_W-1:0] a);
    return ((a >= A_MOD_CFG) && (a <= A_ANG2_GO)) ||
           (a == A_ANG_ROUTE) ||
           ((a >= A_GATE_POL) && (a <= A_CHOP_MODE));
  endfunction

endpackage

/* File: srvrb_stack_sel.sv */
`timescale 1ns/1ps
`default_nettype none
module srvrb_stack_sel #(
  parameter int SUBS = 3
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            reset_n,
  // select write
  input  wire logic                            sel_we,
  input  wire logic [srvrb_pkg::DATA_W-1:0]    sel_wdata,
  // subregisters, entry 0 in the low word
  input  wire logic [SUBS*srvrb_pkg::DATA_W-1:0] sub_data,
  // visible state
  output logic      [srvrb_pkg::DATA_W-1:0]    sel_r,
  output logic      [srvrb_pkg::DATA_W-1:0]    data_out
);
  import srvrb_pkg::*;

  if (SUBS < 1) begin : g_chk
    $error("srvrb_stack_sel needs at least one subregister");
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) sel_r <= SEL_RESET;
    else if (sel_we) sel_r <= sel_wdata;
  end

  // out-of-range selects read as zero
  always_comb begin
    data_out = '0;
    for (int s = 0; s < SUBS; s++) begin
      if (sel_r == DATA_W'(s))
        data_out = sub_data[s*DATA_W +: DATA_W];
    end
  end
endmodule
`default_nettype wire

/* File: srvrb_phase_calc.sv */
`timescale 1ns/1ps
`default_nettype none
module srvrb_phase_calc (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           reset_n,
  // two source phases, measured or externally written
  input  wire logic signed [srvrb_pkg::HALF_W-1:0] cur_ux,
  input  wire logic signed [srvrb_pkg::HALF_W-1:0] cur_wy,
  // all three phases, registered
  output logic signed      [srvrb_pkg::HALF_W-1:0] ph_ux_r,
  output logic signed      [srvrb_pkg::HALF_W-1:0] ph_wy_r,
  output logic signed      [srvrb_pkg::HALF_W-1:0] ph_v_r
);
  import srvrb_pkg::*;

  // two guard bits: negating the most negative sum must not wrap
  logic signed [HALF_W+1:0] sum;
  logic signed [HALF_W+1:0] neg;
  logic signed [HALF_W-1:0] v_nxt;
  localparam logic signed [HALF_W+1:0] MAXV = 18'sh07FFF;
  localparam logic signed [HALF_W+1:0] MINV = 18'sh38000;

  // currents sum to zero; saturate the derived phase
  always_comb begin
    sum = $signed({{2{cur_ux[HALF_W-1]}}, cur_ux}) +
          $signed({{2{cur_wy[HALF_W-1]}}, cur_wy});
    neg = -sum;
    if (neg > MAXV) v_nxt = MAXV[HALF_W-1:0];
    else if (neg < MINV) v_nxt = MINV[HALF_W-1:0];
    else v_nxt = neg[HALF_W-1:0];
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      ph_ux_r <= '0;
      ph_wy_r <= '0;
      ph_v_r  <= '0;
    end else begin
      ph_ux_r <= cur_ux;
      ph_wy_r <= cur_wy;
      ph_v_r  <= v_nxt;
    end
  end
endmodule
`default_nettype wire

/* File: srvrb_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// checker on the register bank ports
// ------
module srvrb_monitor (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        reset_n,
  // bus
  input wire logic [8:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // sources and results
  input wire logic [15:0] meas_cur_ux,
  input wire logic [15:0] meas_cur_wy,
  input wire logic [15:0] ang_ux,
  input wire logic [15:0] ang_wy,
  input wire logic [31:0] current_channel_routing,
  input wire logic [31:0] pwm_period_count,
  input wire logic [15:0] phase_cur_v
);
  import srvrb_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  logic [6:0]         idx;
  logic               take;
  logic [31:0]        conv_sel_r;
  logic signed [17:0] vsum;
  logic [15:0]        v_exp;
  assign idx  = avs_address[8:2];
  assign take = !avs_waitrequest;
  assign vsum = -($signed({{2{meas_cur_ux[15]}}, meas_cur_ux}) +
                  $signed({{2{meas_cur_wy[15]}}, meas_cur_wy}));
  // saturate the derived phase to 16-bit signed
  assign v_exp = (vsum > 18'sh07FFF) ? 16'h7FFF :
                 (vsum < 18'sh38000) ? 16'h8000 : vsum[15:0];
  always_ff @(posedge ref_clk) begin
    if (!reset_n) conv_sel_r <= 32'h0;
    else if (avs_write && take && idx == A_CONV_SEL)
      conv_sel_r <= be_merge(conv_sel_r, avs_writedata, avs_byteenable);
  end
  chk_wait_once: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("wait cycle not ended");
  chk_wait_idle: assert property (
    !avs_read && !avs_write |-> !avs_waitrequest)
    else $error("waitrequest without request");
  chk_word_store: assert property (
    avs_write && take && idx == A_PWM_PER && avs_byteenable == 4'hF
    |=> pwm_period_count == $past(avs_writedata))
    else $error("written word not stored");
  chk_ro_ignore: assert property (
    avs_write && take && (idx == A_IDENT_READ || idx > 7'h1A)
    |=> $stable(pwm_period_count) && $stable(current_channel_routing))
    else $error("refused write changed state");
  chk_sel_echo: assert property (
    avs_read && avs_waitrequest && idx == A_CONV_SEL
    |=> avs_readdata == $past(conv_sel_r))
    else $error("select readback wrong");
  chk_unmapped_zero: assert property (
    avs_read && avs_waitrequest && (idx == 7'h10 || idx > 7'h1A)
    |=> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_third_phase: assert property (
    reset_n && !current_channel_routing[0]
    |=> phase_cur_v == $past(v_exp))
    else $error("third phase wrong");
  chk_angle_pack: assert property (
    avs_read && avs_waitrequest && idx == A_ANG_WY_UX
    |=> avs_readdata == {$past(ang_wy, 2), $past(ang_ux, 2)})
    else $error("angle word wrong");
endmodule
bind srvrb_regbank srvrb_monitor i_srvrb_monitor (
  .ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .meas_cur_ux, .meas_cur_wy, .ang_ux, .ang_wy,
  .current_channel_routing, .pwm_period_count, .phase_cur_v
);
`default_nettype wire

/* File: srvrb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ------
// host side: one word per access, byte lanes chosen by byteenable
// ------
module srvrb_host_model (
  // clock
  input  wire logic        ref_clk,
  // avalon-mm master
  output logic      [8:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // wait limit used up
  output logic             hung
);
  initial begin
    avs_address = 9'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    hung = 1'b0;
  end
  task automatic xfer(input logic w, input logic [6:0] a,
                      input logic [31:0] d, input logic [3:0] be,
                      output logic [31:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= {a, 2'b00};
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 16) begin
      @(posedge ref_clk);
      n++;
    end
    q = avs_readdata;
    if (n == 16) hung <= 1'b1;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // released address and data lines no longer show the last value
    avs_address <= ~{a, 2'b00};
    avs_writedata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import srvrb_pkg::*;
  // identification words, values arbitrary
  localparam logic [31:0] ID0 = 32'h1234_0001;
  localparam logic [31:0] ID1 = 32'h1234_0002;
  localparam logic [31:0] ID2 = 32'h1234_0003;
  logic        ref_clk, reset_n, host_hung;
  logic [8:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata, pwm_period_count;
  logic [3:0]  avs_byteenable;
  logic [31:0] conv_raw [5];
  logic [15:0] cur_ux, cur_wy, ang_ux, ang_v, ang_wy, ang_n;
  logic [31:0] cfg_o [32];
  logic [15:0] ph_ux, ph_wy, ph_v;
  int          err_count, check_count;
  srvrb_regbank #(.IDENT_TYPE(ID0), .IDENT_VERSION(ID1),
    .IDENT_DATE(ID2)) i_srvrb_regbank (
    .ref_clk, .reset_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .conv_raw_0(conv_raw[0]), .conv_raw_1(conv_raw[1]),
    .conv_raw_2(conv_raw[2]), .conv_raw_3(conv_raw[3]),
    .meas_cur_ux(cur_ux), .meas_cur_wy(cur_wy),
    .ang_ux, .ang_v, .ang_wy, .ang_n,
    .modulator_config_pair(cfg_o[A_MOD_CFG]),
    .modulator_clock_a(cfg_o[A_MOD_CLK_A]),
    .modulator_clock_b(cfg_o[A_MOD_CLK_B]),
    .decimation_ratio_pair(cfg_o[A_DECIM]),
    .current_ch1_gain_offset(cfg_o[A_CUR1_GO]),
    .current_ch0_gain_offset(cfg_o[A_CUR0_GO]),
    .current_channel_routing(cfg_o[A_CUR_ROUTE]),
    .external_current_values(cfg_o[A_CUR_EXT]),
    .analog_input_stage_setup(cfg_o[A_AIN_SETUP]),
    .angle_sensor_ch0_gain_offset(cfg_o[A_ANG0_GO]),
    .angle_sensor_ch1_gain_offset(cfg_o[A_ANG1_GO]),
    .angle_sensor_ch2_gain_offset(cfg_o[A_ANG2_GO]),
    .angle_sensor_routing(cfg_o[A_ANG_ROUTE]),
    .gate_output_polarity(cfg_o[A_GATE_POL]),
    .pwm_period_count,
    .dead_time_high_low(cfg_o[A_DEAD_TIME]),
    .chopper_mode_setup(cfg_o[A_CHOP_MODE]),
    .phase_cur_ux(ph_ux), .phase_cur_wy(ph_wy), .phase_cur_v(ph_v)
  );
  srvrb_host_model i_srvrb_host_model (
    .ref_clk, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .hung(host_hung)
  );
  // ------
  // shared tasks
  // ------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d,
                    input logic [3:0] be);
    logic [31:0] q;
    i_srvrb_host_model.xfer(1'b1, a, d, be, q);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_srvrb_host_model.xfer(1'b0, a, 32'h0, 4'hF, q);
    check(q, exp);
  endtask
  function automatic logic in_rw(input logic [6:0] a);
    return (a >= 7'h04 && a <= 7'h0F) || a == 7'h11 ||
           (a >= 7'h17 && a <= 7'h1A);
  endfunction
  task automatic complete_run;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------
  // scenarios
  // ------
  task automatic t_reset;
    rd_chk(A_IDENT_SEL, 32'h0);
    rd_chk(A_IDENT_READ, ID0);
    rd_chk(A_CONV_READ, conv_raw[0]);
  endtask
  task automatic t_map;
    logic [6:0] a;
    for (int i = 0; i < 128; i++) begin
      a = 7'(i);
      if (a != A_IDENT_SEL && a != A_CONV_SEL)
        wr(a, {4{1'b1, a}}, 4'hF);
    end
    for (int i = 0; i < 128; i++) begin
      a = 7'(i);
      if (in_rw(a)) rd_chk(a, {4{1'b1, a}});
      else if (a == 7'h10 || a == 7'h14 || a > 7'h1A)
        rd_chk(a, 32'h0);
    end
    // every configuration output shows its stored word
    for (int i = 4; i < 27; i++) begin
      a = 7'(i);
      if (in_rw(a) && a != A_PWM_PER)
        check(cfg_o[a[4:0]], {4{1'b1, a}});
    end
    check(pwm_period_count, 32'h9898_9898);
    wr(A_PWM_PER, 32'h1122_3344, 4'h5);
    rd_chk(A_PWM_PER, 32'h9822_9844);
  endtask
  task automatic t_stack;
    logic [31:0] ids [4];
    ids = '{ID0, ID1, ID2, 32'h0};
    for (int s = 0; s < 5; s++) begin
      if (s < 4) wr(A_IDENT_SEL, 32'(s), 4'hF);
      if (s < 4) rd_chk(A_IDENT_READ, ids[s]);
      wr(A_CONV_SEL, 32'(s), 4'hF);
      rd_chk(A_CONV_SEL, 32'(s));
      rd_chk(A_CONV_READ, conv_raw[s]);
    end
  endtask
  task automatic t_phase;
    logic [15:0] ux [3], wy [3], v [3];
    ux = '{16'h03E8, 16'h8000, 16'h7FFF};
    wy = '{16'h07D0, 16'h8000, 16'h0002};
    v = '{16'hF448, 16'h7FFF, 16'h8000};
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      cur_ux <= ux[k];
      cur_wy <= wy[k];
      rd_chk(A_PH_WY_UX, {wy[k], ux[k]});
      rd_chk(A_PH_V, {16'h0, v[k]});
      check({ph_wy, ph_ux}, {wy[k], ux[k]});
      check({16'h0, ph_v}, {16'h0, v[k]});
    end
    wr(A_CUR_EXT, 32'hFFFE_0005, 4'hF);
    wr(A_CUR_ROUTE, 32'h1, 4'hF);
    rd_chk(A_PH_V, 32'h0000_FFFD);
    check({ph_wy, ph_ux}, 32'hFFFE_0005);
    check({16'h0, ph_v}, 32'h0000_FFFD);
    ang_ux <= 16'hFFFF;
    ang_v <= 16'h8000;
    rd_chk(A_ANG_WY_UX, 32'h0000_FFFF);
    rd_chk(A_ANG_VN, 32'h0001_8000);
  endtask
  task automatic t_rereset;
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    rd_chk(A_CONV_SEL, 32'h0);
    rd_chk(A_CUR_ROUTE, 32'h0);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (host_hung === 1'b1) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    err_count = 0;
    check_count = 0;
    reset_n = 1'b0;
    cur_ux = 16'h0;
    cur_wy = 16'h0;
    ang_ux = 16'h1234;
    ang_v = 16'h0;
    ang_wy = 16'h0;
    ang_n = 16'h0001;
    conv_raw = '{32'hA000_0001, 32'hA001_0002, 32'hA002_0003,
                 32'hA003_0004, 32'h0};
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_map();
    t_stack();
    t_phase();
    t_rereset();
    complete_run();
  end
endmodule
`default_nettype wire
